// ==== hdl/uart_cfg_regs.svh ====
`ifndef UART_CFG_REGS_SVH
`define UART_CFG_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define ADDR_MODE        8'h00
`define ADDR_CLK_CFG     8'h04
`define ADDR_BAUD        8'h08
`define ADDR_TX_DATA     8'h0c
`define ADDR_RX_DATA     8'h10
`define ADDR_STATUS      8'h14
// ****************************************
// field positions and reset values
// ****************************************
`define MODE_WIDTH       9
`define CLK_CFG_WIDTH    5
`define BAUD_WIDTH       12
`define STAT_TXEND_BIT   2
`define MODE_RESET       9'h000
`define CLK_CFG_RESET    5'h00
`define BAUD_RESET       12'h000
// ****************************************
// timing counts
// ****************************************
`define SAMPLES_DIV16    5'h10
`define SAMPLES_DIV4     5'h04
`define TX_FIFO_DEPTH    8
`define RX_FIFO_DEPTH    2
`endif

// ==== hdl/uart_cfg_pkg.sv ====
package uart_cfg_pkg;
   typedef struct packed {
      logic stop_length_sel;
      logic parity_odd_sel;
      logic parity_enable;
      logic char_length_sel;
      logic tx_opendrain_sel;
      logic rx_pullup_en;
      logic tx_invert;
      logic rx_invert;
      logic baud_prediv_sel;
   } mode_t;
   typedef struct packed {
      logic       run_in_debug;
      logic [1:0] clock_divide_sel;
      logic [1:0] clock_source_sel;
   } clk_cfg_t;
   typedef struct packed {
      logic [3:0] baud_fine_adjust;
      logic [7:0] baud_coarse_value;
   } baud_cfg_t;
   typedef enum logic [2:0] {
      TX_IDLE  = 3'h0,
      TX_START = 3'h1,
      TX_DATA  = 3'h2,
      TX_PAR   = 3'h3,
      TX_STOP  = 3'h4
   } tx_state_t;
   typedef enum logic [2:0] {
      RX_IDLE  = 3'h0,
      RX_START = 3'h1,
      RX_DATA  = 3'h2,
      RX_PAR   = 3'h3,
      RX_STOP  = 3'h4
   } rx_state_t;
endpackage

// ==== hdl/uart_fifo.sv ====
`timescale 1ns/1ps
module uart_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             push, pop;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   always_comb begin
      push        = in_valid && (count != (AW+1)'(DEPTH));
      pop         = out_ready && (count != '0);
      next_wr_ptr = push ? ptr_inc(wr_ptr) : wr_ptr;
      next_rd_ptr = pop ? ptr_inc(rd_ptr) : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         count     <= next_count;
         in_ready  <= next_count != (AW+1)'(DEPTH);
         out_valid <= next_count != '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
      out_data <= (push && next_rd_ptr == wr_ptr) ? in_data : mem[next_rd_ptr];
   end
endmodule

// ==== hdl/uart_baud_gen.sv ====
`timescale 1ns/1ps
module uart_baud_gen (
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire uart_cfg_pkg::clk_cfg_t clk_cfg,
   input  wire uart_cfg_pkg::baud_cfg_t baud_cfg,
   input  wire logic [2:0]             src_tick,
   input  wire logic                   debug_halt,
   output logic                        sample_tick
);
   logic [2:0] div_cnt, next_div_cnt;
   logic [8:0] rate_cnt, next_rate_cnt;
   logic [3:0] fine_phase, next_fine_phase;
   logic       next_tick, src_en, op_en;
   logic [8:0] rate_end;
   logic [2:0] div_mask;
   logic [3:0] src_vec;

   // ****************************************
   // operating clock enable and rate divider
   // ****************************************
   always_comb begin
      src_vec  = {src_tick, 1'b1};                                             // see RL4
      src_en   = src_vec[clk_cfg.clock_source_sel]
                 && (clk_cfg.run_in_debug || !debug_halt);                     // see RL5 see RL6
      div_mask = 3'((4'h1 << clk_cfg.clock_divide_sel) - 4'h1);                // see RL4
      op_en    = src_en && ((div_cnt & div_mask) == 3'h0);                     // see RL4
      next_div_cnt    = src_en ? div_cnt + 3'h1 : div_cnt;
      rate_end        = {1'b0, baud_cfg.baud_coarse_value}
                        + 9'(fine_phase < baud_cfg.baud_fine_adjust);          // see RL8
      next_rate_cnt   = rate_cnt;
      next_fine_phase = fine_phase;
      next_tick       = 1'b0;
      if (op_en) begin
         if (rate_cnt >= rate_end) begin
            next_rate_cnt   = 9'h000;
            next_fine_phase = fine_phase + 4'h1;
            next_tick       = 1'b1;
         end else begin
            next_rate_cnt = rate_cnt + 9'h001;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_cnt     <= 3'h0;
         rate_cnt    <= 9'h000;
         fine_phase  <= 4'h0;
         sample_tick <= 1'b0;
      end else begin
         div_cnt     <= next_div_cnt;
         rate_cnt    <= next_rate_cnt;
         fine_phase  <= next_fine_phase;
         sample_tick <= next_tick;
      end
   end
endmodule

// ==== hdl/uart_frame_baud_pin_config.sv ====
// Overview of operation
// RL1: pull-up request follows the pull-up setting
// RL2: transmit pin push-pull, or open-drain when selected
// RL3: invert receive input and transmit output optionally
// RL4: two-bit source select and two-bit divider
// RL5: debug halts operating clock unless run enabled
// RL6: debug-run keeps operating clock going
// RL7: sampling pre-division of sixteen or four
// RL8: coarse rate plus one, fine adjust trims
// RL9: exactly one start bit per frame
// RL10: seven or eight data bits by length
// RL11: one or two transmitted stop bits
// RL12: odd, even or no parity bit
// RL13: start, data LSB first, parity, stop
// RL14: software routes pins before enabling channel
// RL15: transmit load, busy, and end-of-transmission flags
// RL16: start detection, busy, then two-entry receive FIFO
// RL17: sample bit centres, reject false starts
// RL18: idle transmit line rests high before inversion
`timescale 1ns/1ps
`include "uart_cfg_regs.svh"
module uart_frame_baud_pin_config (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   input  wire logic [2:0]  src_tick,
   input  wire logic        debug_halt,
   input  wire logic        serial_rx_pin,
   output logic             rx_pullup_en,
   output logic             serial_tx_out,
   output logic             serial_tx_oe
);
   // ****************************************
   // registers and status
   // ****************************************
   uart_cfg_pkg::mode_t     mode, next_mode;
   uart_cfg_pkg::clk_cfg_t  clk_cfg, next_clk_cfg;
   uart_cfg_pkg::baud_cfg_t baud_cfg, next_baud_cfg;
   logic [15:0] next_rdata;
   logic        tx_end_flag, next_tx_end_flag;
   logic        tx_busy_flag, next_tx_busy_flag;
   logic        rx_busy_flag, next_rx_busy_flag;
   logic        tx_buffer_empty_flag;
   logic        sample_tick, tx_in_ready, tx_avail, tx_pop, rx_avail, rx_in_ready;
   logic        rx_pop, rx_push, tx_write;
   logic [7:0]  tx_fifo_data, rx_fifo_data, rx_word;

   always_comb begin
      next_mode     = mode;
      next_clk_cfg  = clk_cfg;
      next_baud_cfg = baud_cfg;
      next_rdata    = 16'h0000;
      tx_write      = wr && (addr == `ADDR_TX_DATA);
      rx_pop        = rd && (addr == `ADDR_RX_DATA);
      if (wr) begin
         case (addr)
            `ADDR_MODE:    next_mode     = uart_cfg_pkg::mode_t'(wdata[`MODE_WIDTH-1:0]);
            `ADDR_CLK_CFG: next_clk_cfg  = uart_cfg_pkg::clk_cfg_t'(wdata[`CLK_CFG_WIDTH-1:0]);
            `ADDR_BAUD:    next_baud_cfg = uart_cfg_pkg::baud_cfg_t'(wdata[`BAUD_WIDTH-1:0]);
            default:       next_mode     = mode;
         endcase
      end
      if (rd) begin
         case (addr)
            `ADDR_MODE:    next_rdata = {7'h00, mode};
            `ADDR_CLK_CFG: next_rdata = {11'h000, clk_cfg};
            `ADDR_BAUD:    next_rdata = {4'h0, baud_cfg};
            `ADDR_RX_DATA: next_rdata = rx_avail ? {8'h00, rx_fifo_data} : 16'h0000;
            `ADDR_STATUS:  next_rdata = {9'h000, !tx_in_ready, !rx_in_ready, rx_avail,
                                         rx_busy_flag, tx_end_flag, tx_busy_flag,
                                         tx_buffer_empty_flag};
            default:       next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode         <= `MODE_RESET;
         clk_cfg      <= `CLK_CFG_RESET;
         baud_cfg     <= `BAUD_RESET;
         rdata        <= 16'h0000;
         rx_pullup_en <= 1'b0;
      end else begin
         mode         <= next_mode;
         clk_cfg      <= next_clk_cfg;
         baud_cfg     <= next_baud_cfg;
         rdata        <= next_rdata;
         rx_pullup_en <= next_mode.rx_pullup_en;                               // see RL1
      end
   end

   uart_baud_gen u_baud (
      .core_clk    (core_clk),
      .rst         (rst),
      .clk_cfg     (clk_cfg),
      .baud_cfg    (baud_cfg),
      .src_tick    (src_tick),
      .debug_halt  (debug_halt),
      .sample_tick (sample_tick)
   );

   uart_fifo #(.WIDTH(8), .DEPTH(`TX_FIFO_DEPTH)) u_tx_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (tx_write),
      .in_ready  (tx_in_ready),
      .in_data   (wdata[7:0]),
      .out_valid (tx_avail),
      .out_ready (tx_pop),
      .out_data  (tx_fifo_data)
   );

   uart_fifo #(.WIDTH(8), .DEPTH(`RX_FIFO_DEPTH)) u_rx_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (rx_push),
      .in_ready  (rx_in_ready),
      .in_data   (rx_word),
      .out_valid (rx_avail),
      .out_ready (rx_pop),
      .out_data  (rx_fifo_data)
   );

   assign tx_buffer_empty_flag = !tx_avail;                                   // see RL15

   // ****************************************
   // bit timing
   // ****************************************
   logic [4:0] samples;
   logic [3:0] last_tick, half_tick;
   logic [2:0] last_bit;

   always_comb begin
      samples   = mode.baud_prediv_sel ? `SAMPLES_DIV4 : `SAMPLES_DIV16;     // see RL7
      last_tick = 4'(samples - 5'h01);
      half_tick = 4'((samples >> 1) - 5'h01);
      last_bit  = mode.char_length_sel ? 3'h7 : 3'h6;                        // see RL10
   end

   // ****************************************
   // transmitter
   // ****************************************
   uart_cfg_pkg::tx_state_t tx_state, next_tx_state;
   logic [7:0] tx_shift, next_tx_shift;
   logic [3:0] tx_cnt, next_tx_cnt;
   logic [2:0] tx_idx, next_tx_idx;
   logic       tx_stop2, next_tx_stop2, tx_line, next_tx_line, tx_bit_end, tx_parity;

   always_comb begin
      next_tx_state     = tx_state;
      next_tx_shift     = tx_shift;
      next_tx_cnt       = tx_cnt;
      next_tx_idx       = tx_idx;
      next_tx_stop2     = tx_stop2;
      next_tx_busy_flag = tx_busy_flag;
      next_tx_end_flag  = tx_end_flag;
      tx_pop            = 1'b0;
      tx_bit_end        = sample_tick && (tx_cnt == last_tick);
      tx_parity         = ^(tx_shift & {mode.char_length_sel, 7'h7f})
                          ^ mode.parity_odd_sel;                               // see RL12
      if (wr && addr == `ADDR_STATUS && wdata[`STAT_TXEND_BIT]) begin
         next_tx_end_flag = 1'b0;
      end
      if (sample_tick && tx_state != uart_cfg_pkg::TX_IDLE) begin
         next_tx_cnt = tx_bit_end ? 4'h0 : tx_cnt + 4'h1;
      end
      case (tx_state)
         uart_cfg_pkg::TX_IDLE: begin
            if (sample_tick && tx_avail) begin
               tx_pop            = 1'b1;                                       // see RL15
               next_tx_shift     = tx_fifo_data;
               next_tx_cnt       = 4'h0;
               next_tx_busy_flag = 1'b1;
               next_tx_state     = uart_cfg_pkg::TX_START;
            end
         end
         uart_cfg_pkg::TX_START: begin
            if (tx_bit_end) begin
               next_tx_idx   = 3'h0;
               next_tx_state = uart_cfg_pkg::TX_DATA;                          // see RL9
            end
         end
         uart_cfg_pkg::TX_DATA: begin
            if (tx_bit_end) begin
               next_tx_idx = tx_idx + 3'h1;
               if (tx_idx == last_bit) begin
                  next_tx_stop2 = mode.stop_length_sel;
                  next_tx_state = mode.parity_enable ? uart_cfg_pkg::TX_PAR
                                                     : uart_cfg_pkg::TX_STOP;  // see RL13
               end
            end
         end
         uart_cfg_pkg::TX_PAR: begin
            if (tx_bit_end) begin
               next_tx_state = uart_cfg_pkg::TX_STOP;
            end
         end
         uart_cfg_pkg::TX_STOP: begin
            if (tx_bit_end) begin
               if (tx_stop2) begin
                  next_tx_stop2 = 1'b0;                                        // see RL11
               end else if (tx_avail) begin
                  tx_pop        = 1'b1;
                  next_tx_shift = tx_fifo_data;
                  next_tx_state = uart_cfg_pkg::TX_START;
               end else begin
                  next_tx_busy_flag = 1'b0;
                  next_tx_end_flag  = 1'b1;                                    // see RL15
                  next_tx_state     = uart_cfg_pkg::TX_IDLE;
               end
            end
         end
         default: next_tx_state = uart_cfg_pkg::TX_IDLE;
      endcase
      case (next_tx_state)
         uart_cfg_pkg::TX_START: next_tx_line = 1'b0;
         uart_cfg_pkg::TX_DATA:  next_tx_line = next_tx_shift[next_tx_idx];
         uart_cfg_pkg::TX_PAR:   next_tx_line = tx_parity;
         default:                next_tx_line = 1'b1;                          // see RL18
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_state      <= uart_cfg_pkg::TX_IDLE;
         tx_shift      <= 8'h00;
         tx_cnt        <= 4'h0;
         tx_idx        <= 3'h0;
         tx_stop2      <= 1'b0;
         tx_line       <= 1'b1;
         tx_busy_flag  <= 1'b0;
         tx_end_flag   <= 1'b0;
         serial_tx_out <= 1'b1;
         serial_tx_oe  <= 1'b1;
      end else begin
         tx_state      <= next_tx_state;
         tx_shift      <= next_tx_shift;
         tx_cnt        <= next_tx_cnt;
         tx_idx        <= next_tx_idx;
         tx_stop2      <= next_tx_stop2;
         tx_line       <= next_tx_line;
         tx_busy_flag  <= next_tx_busy_flag;
         tx_end_flag   <= next_tx_end_flag;
         serial_tx_out <= mode.tx_opendrain_sel ? 1'b0 : tx_line ^ mode.tx_invert; // see RL3
         serial_tx_oe  <= mode.tx_opendrain_sel ? !(tx_line ^ mode.tx_invert)
                                                : 1'b1;                         // see RL2
      end
   end

   // ****************************************
   // receiver
   // ****************************************
   uart_cfg_pkg::rx_state_t rx_state, next_rx_state;
   logic [2:0] rx_sync;
   logic       rx_filt, next_rx_filt, rx_bit;
   logic [7:0] rx_data, next_rx_data;
   logic [3:0] rx_cnt, next_rx_cnt;
   logic [2:0] rx_idx, next_rx_idx;

   always_comb begin
      next_rx_filt      = (rx_sync[1] == rx_sync[2]) ? rx_sync[2] : rx_filt;
      rx_bit            = rx_filt ^ mode.rx_invert;                            // see RL3
      next_rx_state     = rx_state;
      next_rx_data      = rx_data;
      next_rx_cnt       = sample_tick ? rx_cnt + 4'h1 : rx_cnt;
      next_rx_idx       = rx_idx;
      next_rx_busy_flag = rx_busy_flag;
      rx_push           = 1'b0;
      rx_word           = rx_data & {mode.char_length_sel, 7'h7f};
      case (rx_state)
         uart_cfg_pkg::RX_IDLE: begin
            next_rx_cnt = 4'h0;
            if (sample_tick && !rx_bit) begin
               next_rx_busy_flag = 1'b1;                                       // see RL16
               next_rx_state     = uart_cfg_pkg::RX_START;
            end
         end
         uart_cfg_pkg::RX_START: begin
            if (sample_tick && rx_cnt == half_tick) begin
               next_rx_cnt = 4'h0;
               next_rx_idx = 3'h0;
               if (rx_bit) begin
                  next_rx_busy_flag = 1'b0;
                  next_rx_state     = uart_cfg_pkg::RX_IDLE;                   // see RL17
               end else begin
                  next_rx_state = uart_cfg_pkg::RX_DATA;
               end
            end
         end
         uart_cfg_pkg::RX_DATA: begin
            if (sample_tick && rx_cnt == last_tick) begin
               next_rx_cnt          = 4'h0;
               next_rx_data[rx_idx] = rx_bit;                                  // see RL17
               next_rx_idx          = rx_idx + 3'h1;
               if (rx_idx == last_bit) begin
                  next_rx_state = mode.parity_enable ? uart_cfg_pkg::RX_PAR
                                                     : uart_cfg_pkg::RX_STOP;
               end
            end
         end
         uart_cfg_pkg::RX_PAR: begin
            if (sample_tick && rx_cnt == last_tick) begin
               next_rx_cnt   = 4'h0;
               next_rx_state = uart_cfg_pkg::RX_STOP;
            end
         end
         uart_cfg_pkg::RX_STOP: begin
            if (sample_tick && rx_cnt == last_tick) begin
               rx_push           = 1'b1;                                       // see RL16
               next_rx_busy_flag = 1'b0;
               next_rx_state     = uart_cfg_pkg::RX_IDLE;
            end
         end
         default: next_rx_state = uart_cfg_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_sync      <= 3'h7;
         rx_filt      <= 1'b1;
         rx_state     <= uart_cfg_pkg::RX_IDLE;
         rx_data      <= 8'h00;
         rx_cnt       <= 4'h0;
         rx_idx       <= 3'h0;
         rx_busy_flag <= 1'b0;
      end else begin
         rx_sync      <= {rx_sync[1:0], serial_rx_pin};
         rx_filt      <= next_rx_filt;
         rx_state     <= next_rx_state;
         rx_data      <= next_rx_data;
         rx_cnt       <= next_rx_cnt;
         rx_idx       <= next_rx_idx;
         rx_busy_flag <= next_rx_busy_flag;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_pullup_follow: assert property (wr && addr == `ADDR_MODE |=> ##1 // see RL1
      rx_pullup_en == $past(wdata[3], 2)) else $error("pull-up request mismatch");
   chk_opendrain_low: assert property ($past(mode.tx_opendrain_sel) |-> // see RL2
      !serial_tx_out) else $error("open-drain pin driven high");
   chk_tx_invert: assert property (!$past(mode.tx_opendrain_sel) |-> // see RL3
      serial_tx_out == ($past(tx_line) ^ $past(mode.tx_invert)))
      else $error("transmit polarity wrong");
   chk_debug_freeze: assert property ((debug_halt && !clk_cfg.run_in_debug)[*2] // see RL5
      |-> !sample_tick) else $error("sampling clock ran in debug");
   chk_start_single: assert property (tx_state == uart_cfg_pkg::TX_START && tx_bit_end // see RL9
      |=> tx_state == uart_cfg_pkg::TX_DATA && tx_idx == 3'h0)
      else $error("start bit not single");
   chk_data_length: assert property (tx_state == uart_cfg_pkg::TX_DATA && tx_bit_end // see RL10
      && tx_idx == (mode.char_length_sel ? 3'h7 : 3'h6) |=> tx_state != uart_cfg_pkg::TX_DATA)
      else $error("data length wrong");
   chk_parity_skip: assert property (tx_state == uart_cfg_pkg::TX_DATA && tx_bit_end // see RL12
      && tx_idx == last_bit && !mode.parity_enable |=> tx_state == uart_cfg_pkg::TX_STOP)
      else $error("parity bit sent while disabled");
   chk_stop_two: assert property (tx_state == uart_cfg_pkg::TX_STOP && tx_bit_end // see RL11
      && tx_stop2 |=> tx_state == uart_cfg_pkg::TX_STOP) else $error("second stop missing");
   chk_idle_mark: assert property (tx_state == uart_cfg_pkg::TX_IDLE |-> tx_line) // see RL18
      else $error("idle line not high");
   chk_tx_busy: assert property (tx_state == uart_cfg_pkg::TX_START |-> tx_busy_flag) // see RL15
      else $error("busy not set during start");
   chk_false_start: assert property (rx_state == uart_cfg_pkg::RX_START && sample_tick // see RL17
      && rx_cnt == half_tick && rx_bit |=> rx_state == uart_cfg_pkg::RX_IDLE && !rx_busy_flag)
      else $error("false start accepted");
   cov_frame_sent: cover property (tx_state == uart_cfg_pkg::TX_STOP ##1 tx_end_flag);
   cov_word_received: cover property (rx_push);
   cov_parity_frame: cover property (tx_state == uart_cfg_pkg::TX_PAR);
endmodule

// ==== tb/serial_peer.sv ====
`timescale 1ns/1ps
module serial_peer (
   input  wire logic core_clk,
   output logic      line
);
   // ****************************************
   // far-side transmitter, 8 cycles a bit
   // ****************************************
   initial line = 1'b1;
   // start low, data lsb first, one stop, idle mark
   task automatic send(input logic [7:0] d, input int nbits, input bit inv);
      logic [10:0] fr;
      fr = {2'b11, d, 1'b0};
      for (int i = 0; i < nbits + 2; i++) begin
         line <= ((i == nbits + 1) | fr[i]) ^ inv;
         repeat (8) @(posedge core_clk);
      end
   endtask
   // short low pulse, gone before bit centre
   task automatic glitch();
      line <= 1'b0;
      repeat (2) @(posedge core_clk);
      line <= 1'b1;
   endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "uart_cfg_regs.svh"
module tb_top;
   // ****************************************
   // stimulus and checks
   // ****************************************
   logic [7:0]  addr;
   logic [15:0] wdata, rdata, rv;
   logic        core_clk, rst, wr, rd, debug_halt, rx_line, rx_pullup_en;
   logic [2:0]  src_tick;
   logic        serial_tx_out, serial_tx_oe, tx_wire;
   int          fail_count, n_compared;
   logic [8:0]  modes [6] = '{9'h0e1, 9'h141, 9'h035, 9'h128, 9'h061, 9'h0a1};
   logic [7:0]  datas [6] = '{8'ha5, 8'hd3, 8'h3c, 8'h81, 8'hc6, 8'h7e};
   logic [15:0] clks [6] = '{16'h0000, 16'h0000, 16'h0004, 16'h0000, 16'h0001, 16'h000c};
   int          bcs [6] = '{8, 8, 16, 32, 16, 64};
   assign tx_wire = serial_tx_oe ? serial_tx_out : 1'b1;
   uart_frame_baud_pin_config u_uart_frame_baud_pin_config (.core_clk(core_clk), .rst(rst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .src_tick(src_tick),
      .debug_halt(debug_halt), .serial_rx_pin(rx_line), .rx_pullup_en(rx_pullup_en),
      .serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe));
   serial_peer u_serial_peer (.core_clk(core_clk), .line(rx_line));
   always @(posedge core_clk) begin
      src_tick <= rst ? 3'h0 : {3{!src_tick[0]}};
   end
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      #200000;
      fail_count++;
      results();
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge core_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // sample every bit of one frame at its centre, then the idle after it
   task automatic tx_frame(input logic [8:0] m, input logic [7:0] d, input int bc, input bit load);
      logic [11:0] exp;
      logic [7:0]  dm;
      int          nb;
      dm = d & (m[5] ? 8'hff : 8'h7f);
      nb = 9 + m[5] + m[6] + m[8];
      exp = 12'hfff;
      exp[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         exp[i + 1] = (i < 7 + m[5]) ? dm[i] : 1'b1;
      end
      if (m[6]) begin
         exp[8 + m[5]] = (^dm) ^ m[7];
      end
      if (load) begin
         wr_reg(`ADDR_TX_DATA, {8'h00, d});
      end
      for (int t = 0; t < 2000 && tx_wire !== m[2]; t++) @(posedge core_clk);
      repeat (bc / 2) @(posedge core_clk);
      for (int i = 0; i <= nb; i++) begin
         check("tx level", 16'(tx_wire ^ m[2]), 16'(exp[i]));
         check("tx enable", 16'(serial_tx_oe), 16'(!m[4] || !(exp[i] ^ m[2])));
         repeat (bc) @(posedge core_clk);
      end
      rd_reg(`ADDR_STATUS, rv);
      check("tx status", rv & 16'h0007, 16'h0005);
      wr_reg(`ADDR_STATUS, 16'h0004);
   endtask
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      debug_halt = 1'b0;
      repeat (16) @(posedge core_clk);
      check("reset pins", {rdata[13:0], rx_pullup_en, tx_wire}, 16'h0001);
      rst <= 1'b0;
      wr_reg(`ADDR_BAUD, 16'h0001);
      for (int k = 0; k < 6; k++) begin
         wr_reg(`ADDR_CLK_CFG, clks[k]);
         wr_reg(`ADDR_MODE, {7'h00, modes[k]});
         rd_reg(`ADDR_MODE, rv);
         check("mode", rv, {7'h00, modes[k]});
         check("pullup", 16'(rx_pullup_en), 16'(modes[k][3]));
         tx_frame(modes[k], datas[k], bcs[k], 1'b1);
      end
      wr_reg(`ADDR_CLK_CFG, 16'h0000);
      debug_halt <= 1'b1;
      wr_reg(`ADDR_TX_DATA, 16'h005a);
      repeat (100) @(posedge core_clk);
      check("halted line", 16'(tx_wire), 16'h0001);
      rd_reg(`ADDR_STATUS, rv);
      check("halted status", rv & 16'h0003, 16'h0000);
      debug_halt <= 1'b0;
      tx_frame(9'h0a1, 8'h5a, 8, 1'b0);
      wr_reg(`ADDR_CLK_CFG, 16'h0010);
      debug_halt <= 1'b1;
      tx_frame(9'h0a1, 8'h69, 8, 1'b1);
      debug_halt <= 1'b0;
      wr_reg(`ADDR_MODE, 16'h0021);
      u_serial_peer.glitch();
      repeat (100) @(posedge core_clk);
      rd_reg(`ADDR_RX_DATA, rv);
      check("false start", rv, 16'h0000);
      for (int k = 0; k < 3; k++) begin
         wr_reg(`ADDR_MODE, (k == 1) ? 16'h0001 : (k == 2) ? 16'h0023 : 16'h0021);
         u_serial_peer.send(8'h96, (k == 1) ? 7 : 8, k == 2);
         repeat (16) @(posedge core_clk);
         rd_reg(`ADDR_STATUS, rv);
         check("rx status", rv & 16'h0018, 16'h0010);
         rd_reg(`ADDR_RX_DATA, rv);
         check("rx word", rv, (k == 1) ? 16'h0016 : 16'h0096);
      end
      rd_reg(8'h20, rv);
      check("unmapped", rv, 16'h0000);
      results();
   end
endmodule
